// File: shared/ang_defs.vh
// register map, field positions, reset values and timing counts of the negotiation block
`ifndef ANG_DEFS_VH
`define ANG_DEFS_VH

// management register addresses (5-bit register field of the serial frame)
`define ANG_ADDR_BASIC_CONTROL 5'h00
`define ANG_ADDR_BASIC_STATUS 5'h01
`define ANG_ADDR_ADVERT 5'h04
`define ANG_ADDR_PARTNER 5'h05
`define ANG_ADDR_EXPANSION 5'h06
`define ANG_ADDR_LINE_STATUS 5'h10

// basic control fields
`define ANG_CTL_SOFT_RESET 15
`define ANG_CTL_SPEED 13
`define ANG_CTL_AN_EN 12
`define ANG_CTL_RESTART 9
`define ANG_CTL_DUPLEX 8

// basic status: fixed ability bits (T4 at bit 15 stays zero)
`define ANG_STS_FIXED 16'h7849
`define ANG_STS_AN_DONE 5
`define ANG_STS_RFAULT 4
`define ANG_STS_LINK 2

// advertisement and partner word fields
`define ANG_ADV_SELECTOR 16'h0001
`define ANG_ADV_WR_MASK 16'hA5E0
`define ANG_PG_NEXT 15
`define ANG_PG_RFAULT 13
`define ANG_ABIL_HI 8
`define ANG_ABIL_LO 5

// strap decode of advertised ability bits [8:5] = 100FD,100HD,10FD,10HD
`define ANG_STRAP_00 4'h3
`define ANG_STRAP_01 4'hC
`define ANG_STRAP_10 4'h5
`define ANG_STRAP_11 4'hF

// partner word loaded on parallel detection
`define ANG_PD_WORD_100 16'h0081
`define ANG_PD_WORD_10 16'h0021

// expansion fields
`define ANG_EXP_PD_FAULT 4
`define ANG_EXP_LP_NP 3
`define ANG_EXP_NP_ABLE 2
`define ANG_EXP_PAGE_RX 1
`define ANG_EXP_LP_AN 0

// line status fields
`define ANG_LST_LINK 0
`define ANG_LST_SPEED10 1
`define ANG_LST_DUPLEX 2
`define ANG_LST_AN_DONE 4

// management frame opcodes
`define ANG_OP_READ 2'h2
`define ANG_OP_WRITE 2'h1

// break link time and clock rate
`define ANG_BREAK_MS 1500
`define ANG_CLK_KHZ 20000
`define ANG_BREAK_CYCLES (`ANG_BREAK_MS * `ANG_CLK_KHZ)

`endif

// File: verilog/ang_mgmt_serial.v
// serial management frame slave: decodes frames sampled on mdc rising edges
`timescale 1ns/1ps
`include "ang_defs.vh"

module ang_mgmt_serial #(
   parameter [4:0] PHY_ADDR = 5'h01
) (
   input wire clk,
   input wire sys_rst,
   input wire mdc,
   input wire mdio_i,
   output reg mdio_o,
   output reg mdio_oe,
   output reg [4:0] reg_addr,
   output reg [15:0] reg_wdata,
   output reg reg_wr,
   output reg reg_rd,
   input wire [15:0] reg_rdata
);
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_HDR = 4'h2;
   localparam [3:0] S_TA = 4'h4;
   localparam [3:0] S_DATA = 4'h8;

   reg [3:0] state_q;
   reg [3:0] cnt_q;
   reg [11:0] hdr_q;
   reg [15:0] sh_q;
   reg own_q;
   reg rd_q;
   reg mdc_prev_q;
   wire rise;
   wire [12:0] hdr_full;

   assign rise = mdc & ~mdc_prev_q;
   assign hdr_full = {hdr_q, mdio_i};

   // one frame step per mdc rise; mdc must stay well below clk rate
   always @(posedge clk) begin
      mdc_prev_q <= mdc;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      if (sys_rst) begin
         state_q <= S_IDLE;
         cnt_q <= 4'h0;
         hdr_q <= 12'h000;
         sh_q <= 16'h0000;
         own_q <= 1'b0;
         rd_q <= 1'b0;
         mdio_o <= 1'b0;
         mdio_oe <= 1'b0;
         reg_addr <= 5'h00;
         reg_wdata <= 16'h0000;
      end else if (rise) begin
         case (state_q)
            S_IDLE: begin
               // preamble of ones is optional, a zero starts the frame
               if (!mdio_i) begin
                  state_q <= S_HDR;
                  cnt_q <= 4'h0;
               end
            end
            S_HDR: begin
               hdr_q <= hdr_full[11:0];
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == 4'hC) begin
                  own_q <= hdr_full[12] && (hdr_full[9:5] == PHY_ADDR) &&
                     (hdr_full[11:10] == `ANG_OP_READ || hdr_full[11:10] == `ANG_OP_WRITE);
                  rd_q <= (hdr_full[11:10] == `ANG_OP_READ);
                  reg_addr <= hdr_full[4:0];
                  cnt_q <= 4'h0;
                  state_q <= S_TA;
               end
            end
            S_TA: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == 4'h0) begin
                  // second turnaround bit is driven low on reads
                  mdio_oe <= own_q & rd_q;
                  mdio_o <= 1'b0;
               end else begin
                  mdio_o <= reg_rdata[15];
                  sh_q <= {reg_rdata[14:0], 1'b0};
                  // read strobe with the latch, so a clear-on-read flag is reported first
                  reg_rd <= own_q & rd_q;
                  cnt_q <= 4'h0;
                  state_q <= S_DATA;
               end
            end
            S_DATA: begin
               cnt_q <= cnt_q + 4'h1;
               if (rd_q) begin
                  mdio_o <= sh_q[15];
                  sh_q <= {sh_q[14:0], 1'b0};
               end else begin
                  sh_q <= {sh_q[14:0], mdio_i};
               end
               if (cnt_q == 4'hF) begin
                  mdio_oe <= 1'b0;
                  mdio_o <= 1'b0;
                  reg_wr <= own_q & ~rd_q;
                  reg_wdata <= {sh_q[14:0], mdio_i};
                  state_q <= S_IDLE;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule // ang_mgmt_serial

// File: verilog/ang_autoneg.v
// auto-negotiation control, status and mode resolution of a 10/100 transceiver
// How it works
// - straps are sampled during reset and load advertisement bits 8..5
// - strap pair selects 10 both duplex, 100 both, both half, or all four
// - advertisement register writes override the strapped setup at any time after reset
// - while enabled, advertisement contents are sent as the burst code word
// - common mode priority: 100 full, 100 half, 10 full, 10 half
// - basic control holds one enable bit (zero disables) and a separate restart control
// - negotiation off: speed and duplex bits force the operating mode
// - negotiation on: speed and duplex bits have no effect on the mode
// - line status register reports link speed once link is up
// - status ability bits fixed at one, T4 bit fixed at zero
// - status reports completion, remote fault, link and preamble suppression
// - advertisement offers the strapped abilities by default; cleared bits restrict choice
// - partner register captures base page and every next page received
// - parallel detection loads partner register with 0081h or 0021h
// - expansion reports detect fault, partner next page, own next page, page, partner able
// - exactly four modes: 10 and 100, each half and full duplex
// - writing one to control bit 9 with bit 12 set restarts negotiation at any time
// - restart halts pulses for the break time, then bursts resume
// - detect fault set whenever the 100 and the 10 link are both seen during negotiation
`timescale 1ns/1ps
`include "ang_defs.vh"

module ang_autoneg #(
   parameter [4:0] PHY_ADDR = 5'h01,
   parameter [31:0] BREAK_CYCLES = `ANG_BREAK_CYCLES
) (
   input wire clk,
   input wire sys_rst,
   input wire adv_strap_hi,
   input wire adv_strap_lo,
   input wire mdc,
   input wire mdio_i,
   output wire mdio_o,
   output wire mdio_oe,
   input wire rx_page_valid,
   input wire [15:0] rx_page,
   input wire pd_link_100,
   input wire pd_link_10,
   input wire link_ok,
   output reg flp_tx,
   output reg [15:0] tx_word,
   output reg tx_halt,
   output reg speed_100,
   output reg full_duplex,
   output reg an_done
);
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_BREAK = 4'h2;
   localparam [3:0] ST_FLP = 4'h4;
   localparam [3:0] ST_DONE = 4'h8;

   // resolve the common ability set to {speed_100, full_duplex}
   function [1:0] resolve;
      input [3:0] common;
      begin
         if (common[3])
            resolve = 2'h3;
         else if (common[2])
            resolve = 2'h2;
         else if (common[1])
            resolve = 2'h1;
         else
            resolve = 2'h0;
      end
   endfunction

   // strap pair to advertised ability bits
   function [3:0] strap_abil;
      input hi;
      input lo;
      begin
         case ({hi, lo})
            2'h0: strap_abil = `ANG_STRAP_00;
            2'h1: strap_abil = `ANG_STRAP_01;
            2'h2: strap_abil = `ANG_STRAP_10;
            default: strap_abil = `ANG_STRAP_11;
         endcase
      end
   endfunction

   wire [4:0] reg_addr;
   wire [15:0] reg_wdata;
   wire reg_wr;
   wire reg_rd;
   reg [15:0] rdata_q;
   reg [15:0] rdata_d;

   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [31:0] brk_cnt_q;
   reg an_en_q;
   reg speed_q;
   reg dup_q;
   reg restart_q;
   reg [15:0] advert_q;
   reg [3:0] strap_q;
   reg [15:0] lpar_q;
   reg [15:0] base_q;
   reg base_seen_q;
   reg lp_able_q;
   reg lp_np_q;
   reg page_rx_q;
   reg pdf_q;
   reg rfault_q;

   wire wr_ctl;
   wire wr_adv;
   wire rd_exp;
   wire pg_take;
   wire pg_last;
   wire [15:0] base_word;
   wire [3:0] common;
   wire [1:0] res;
   wire an_ok;
   wire pd_one;
   wire pd_bad;

   ang_mgmt_serial #(
      .PHY_ADDR(PHY_ADDR)
   ) u_mgmt (
      .clk(clk),
      .sys_rst(sys_rst),
      .mdc(mdc),
      .mdio_i(mdio_i),
      .mdio_o(mdio_o),
      .mdio_oe(mdio_oe),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(rdata_q)
   );

   // register strobes from the management frame slave
   assign wr_ctl = reg_wr && (reg_addr == `ANG_ADDR_BASIC_CONTROL);
   assign wr_adv = reg_wr && (reg_addr == `ANG_ADDR_ADVERT);
   assign rd_exp = reg_rd && (reg_addr == `ANG_ADDR_EXPANSION);

   // page exchange; resolution always uses the base page, not next pages
   assign pg_take = (state_q == ST_FLP) && rx_page_valid;
   assign pg_last = pg_take && !rx_page[`ANG_PG_NEXT];
   assign base_word = base_seen_q ? base_q : rx_page;
   assign common = advert_q[`ANG_ABIL_HI:`ANG_ABIL_LO] &
      base_word[`ANG_ABIL_HI:`ANG_ABIL_LO];
   assign res = resolve(common);
   assign an_ok = pg_last && (common != 4'h0);

   // parallel detection only while no page arrives and no next page exchange is open
   assign pd_one = (state_q == ST_FLP) && !base_seen_q && !rx_page_valid &&
      (pd_link_100 ^ pd_link_10);
   assign pd_bad = (state_q == ST_FLP) && pd_link_100 && pd_link_10;

   // negotiation sequencer; disable and restart take priority over progress
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (an_en_q)
               state_d = ST_BREAK;
         end
         ST_BREAK: begin
            if (brk_cnt_q >= BREAK_CYCLES - 32'h1)
               state_d = ST_FLP;
         end
         ST_FLP: begin
            if (an_ok || pd_one)
               state_d = ST_DONE;
         end
         ST_DONE: begin
            // lost link: negotiation resumes without the break
            if (!link_ok)
               state_d = ST_FLP;
         end
         default: begin
            state_d = ST_FLP;
         end
      endcase
      if (!an_en_q)
         state_d = ST_IDLE;
      else if (restart_q)
         state_d = ST_BREAK;
   end

   // sequencer state and break timer
   always @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_FLP;
         brk_cnt_q <= 32'h0;
      end else begin
         state_q <= state_d;
         if (state_q != ST_BREAK || restart_q)
            brk_cnt_q <= 32'h0;
         else
            brk_cnt_q <= brk_cnt_q + 32'h1;
      end
   end

   // basic control; restart self-clears one cycle after it is written
   always @(posedge clk) begin
      if (sys_rst || (wr_ctl && reg_wdata[`ANG_CTL_SOFT_RESET])) begin
         an_en_q <= 1'b1;
         speed_q <= 1'b1;
         dup_q <= 1'b1;
         restart_q <= 1'b0;
      end else if (wr_ctl) begin
         an_en_q <= reg_wdata[`ANG_CTL_AN_EN];
         speed_q <= reg_wdata[`ANG_CTL_SPEED];
         dup_q <= reg_wdata[`ANG_CTL_DUPLEX];
         restart_q <= reg_wdata[`ANG_CTL_RESTART];
      end else begin
         restart_q <= 1'b0;
      end
   end

   // straps caught while reset is held; soft reset restores the strapped value
   always @(posedge clk) begin
      if (sys_rst) begin
         strap_q <= strap_abil(adv_strap_hi, adv_strap_lo);
         advert_q <= `ANG_ADV_SELECTOR |
            {7'h00, strap_abil(adv_strap_hi, adv_strap_lo), 5'h00};
      end else if (wr_ctl && reg_wdata[`ANG_CTL_SOFT_RESET]) begin
         advert_q <= `ANG_ADV_SELECTOR | {7'h00, strap_q, 5'h00};
      end else if (wr_adv) begin
         // selector field stays fixed, reserved bits stay zero
         advert_q <= `ANG_ADV_SELECTOR | (reg_wdata & `ANG_ADV_WR_MASK);
      end
   end

   // partner word capture and expansion flags; a set beats a read clear
   always @(posedge clk) begin
      if (sys_rst) begin
         lpar_q <= 16'h0000;
         base_q <= 16'h0000;
         base_seen_q <= 1'b0;
         lp_able_q <= 1'b0;
         lp_np_q <= 1'b0;
         page_rx_q <= 1'b0;
         pdf_q <= 1'b0;
         rfault_q <= 1'b0;
      end else begin
         if (state_q == ST_BREAK || state_q == ST_IDLE) begin
            base_seen_q <= 1'b0;
            rfault_q <= 1'b0;
         end
         if (pg_take) begin
            lpar_q <= rx_page;
            lp_able_q <= 1'b1;
            if (!base_seen_q) begin
               base_q <= rx_page;
               lp_np_q <= rx_page[`ANG_PG_NEXT];
               rfault_q <= rx_page[`ANG_PG_RFAULT];
            end
            // a last page ends the exchange; the next page is a fresh base
            base_seen_q <= !pg_last;
         end else if (pd_one) begin
            lpar_q <= pd_link_100 ? `ANG_PD_WORD_100 : `ANG_PD_WORD_10;
            lp_able_q <= 1'b0;
         end
         if (pg_take)
            page_rx_q <= 1'b1;
         else if (rd_exp)
            page_rx_q <= 1'b0;
         if (pd_bad)
            pdf_q <= 1'b1;
         else if (rd_exp)
            pdf_q <= 1'b0;
      end
   end

   // operating mode and link side outputs, all registered
   always @(posedge clk) begin
      if (sys_rst) begin
         speed_100 <= 1'b0;
         full_duplex <= 1'b0;
         flp_tx <= 1'b0;
         tx_halt <= 1'b0;
         an_done <= 1'b0;
         tx_word <= 16'h0000;
      end else begin
         if (!an_en_q) begin
            speed_100 <= speed_q;
            full_duplex <= dup_q;
         end else if (state_q == ST_FLP && an_ok) begin
            speed_100 <= res[1];
            full_duplex <= res[0];
         end else if (pd_one) begin
            // parallel detection can only find half duplex
            speed_100 <= pd_link_100;
            full_duplex <= 1'b0;
         end
         flp_tx <= (state_d == ST_FLP);
         tx_halt <= (state_d == ST_BREAK);
         an_done <= (state_d == ST_DONE);
         tx_word <= advert_q;
      end
   end

   // read data mux, held in a flop for the serial slave to shift out
   always @* begin
      rdata_d = 16'h0000;
      case (reg_addr)
         `ANG_ADDR_BASIC_CONTROL: begin
            rdata_d[`ANG_CTL_SPEED] = speed_q;
            rdata_d[`ANG_CTL_AN_EN] = an_en_q;
            rdata_d[`ANG_CTL_RESTART] = restart_q;
            rdata_d[`ANG_CTL_DUPLEX] = dup_q;
         end
         `ANG_ADDR_BASIC_STATUS: begin
            rdata_d = `ANG_STS_FIXED;
            rdata_d[`ANG_STS_AN_DONE] = an_done;
            rdata_d[`ANG_STS_RFAULT] = rfault_q;
            rdata_d[`ANG_STS_LINK] = link_ok;
         end
         `ANG_ADDR_ADVERT: begin
            rdata_d = advert_q;
         end
         `ANG_ADDR_PARTNER: begin
            rdata_d = lpar_q;
         end
         `ANG_ADDR_EXPANSION: begin
            rdata_d[`ANG_EXP_PD_FAULT] = pdf_q;
            rdata_d[`ANG_EXP_LP_NP] = lp_np_q;
            rdata_d[`ANG_EXP_NP_ABLE] = 1'b1;
            rdata_d[`ANG_EXP_PAGE_RX] = page_rx_q;
            rdata_d[`ANG_EXP_LP_AN] = lp_able_q;
         end
         `ANG_ADDR_LINE_STATUS: begin
            // speed only meaningful once the link is up
            rdata_d[`ANG_LST_LINK] = link_ok;
            rdata_d[`ANG_LST_SPEED10] = link_ok & ~speed_100;
            rdata_d[`ANG_LST_DUPLEX] = full_duplex;
            rdata_d[`ANG_LST_AN_DONE] = an_done;
         end
         default: begin
            rdata_d = 16'h0000;
         end
      endcase
   end

   always @(posedge clk) begin
      if (sys_rst)
         rdata_q <= 16'h0000;
      else
         rdata_q <= rdata_d;
   end
endmodule // ang_autoneg

// File: bench/ang_autoneg_checker.sv
// assertions on the negotiation block's link side and break timing
`timescale 1ns/1ps

module ang_autoneg_checker #(
   parameter [31:0] BREAK_CYCLES = 32'h0000_0014
) (
   input wire clk,
   input wire sys_rst,
   input wire rx_page_valid,
   input wire [15:0] rx_page,
   input wire pd_link_100,
   input wire link_ok,
   input wire flp_tx,
   input wire [15:0] tx_word,
   input wire tx_halt,
   input wire speed_100,
   input wire full_duplex,
   input wire an_done
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   logic [31:0] halt_cnt_q;
   logic more_q;
   logic [3:0] base_abil_q;
   // resolution uses the base page abilities, next pages carry other data
   wire [3:0] page_abil = more_q ? base_abil_q : rx_page[8:5];
   wire [3:0] common = tx_word[8:5] & page_abil;
   wire last_page = flp_tx && rx_page_valid && !rx_page[15];
   wire exp_spd = common[3] | common[2];
   wire exp_full = common[3] | (!common[2] & common[1]);

   // length of the current break, a counter since the break is far beyond a repetition
   always @(posedge clk) begin
      if (sys_rst || !tx_halt)
         halt_cnt_q <= 32'h0000_0000;
      else
         halt_cnt_q <= halt_cnt_q + 32'h0000_0001;
   end

   // base page abilities held while next pages follow
   always @(posedge clk) begin
      if (sys_rst || !flp_tx) begin
         more_q <= 1'b0;
         base_abil_q <= 4'h0;
      end else if (rx_page_valid) begin
         more_q <= rx_page[15];
         if (!more_q)
            base_abil_q <= rx_page[8:5];
      end
   end

   a_page_resolve: assert property (last_page && common != 4'h0 |=> an_done
      && speed_100 == $past(exp_spd) && full_duplex == $past(exp_full))
      else $error("page did not resolve to the best common mode");
   a_no_common: assert property (last_page && common == 4'h0 |=> !an_done && flp_tx)
      else $error("page without common ability completed");
   a_pd_mode: assert property ($rose(an_done) && !$past(rx_page_valid) |->
      !full_duplex && speed_100 == $past(pd_link_100))
      else $error("parallel detect mode wrong");
   a_break_len: assert property ($fell(tx_halt) |->
      halt_cnt_q >= BREAK_CYCLES && halt_cnt_q <= BREAK_CYCLES + 1)
      else $error("break time has the wrong length");
   a_break_quiet: assert property (tx_halt |-> !flp_tx && !an_done)
      else $error("pulses sent during break");
   a_break_resume: assert property ($fell(tx_halt) |-> ##[0:2] flp_tx)
      else $error("bursts did not resume after break");
   a_word_fixed: assert property (!$past(sys_rst) |-> (tx_word & 16'h5A1E) == 16'h0000 && tx_word[0])
      else $error("sent word holds bits outside the advertisement");
   a_link_drop: assert property (an_done && !link_ok |-> ##[1:2] !an_done)
      else $error("completion kept after link loss");

   c_page: cover property (last_page && common != 4'h0);
   c_pd: cover property ($rose(an_done) && !$past(rx_page_valid));
   c_break: cover property ($fell(tx_halt));
endmodule // ang_autoneg_checker

bind ang_autoneg ang_autoneg_checker #(.BREAK_CYCLES(BREAK_CYCLES)) ang_autoneg_checker_i (
   .clk(clk), .sys_rst(sys_rst), .rx_page_valid(rx_page_valid), .rx_page(rx_page),
   .pd_link_100(pd_link_100), .link_ok(link_ok), .flp_tx(flp_tx), .tx_word(tx_word),
   .tx_halt(tx_halt), .speed_100(speed_100), .full_duplex(full_duplex), .an_done(an_done));

// File: bench/ang_link_partner.sv
// model of the remote link partner: received pages and receiver link levels
`timescale 1ns/1ps

module ang_link_partner (
   input wire clk,
   output logic rx_page_valid = 1'b0,
   output logic [15:0] rx_page = 16'hA5A5,
   output logic pd_link_100 = 1'b0,
   output logic pd_link_10 = 1'b0,
   output logic link_ok = 1'b0
);
   // one page per call; word inverted afterwards so nothing stale looks valid
   task automatic page(input logic [15:0] w);
      @(posedge clk);
      #1;
      rx_page_valid = 1'b1;
      rx_page = w;
      @(posedge clk);
      #1;
      rx_page_valid = 1'b0;
      rx_page = ~w;
   endtask

   // receiver levels as seen from the line
   task automatic levels(input logic lk, input logic p100, input logic p10);
      @(posedge clk);
      #1;
      link_ok = lk;
      pd_link_100 = p100;
      pd_link_10 = p10;
   endtask
endmodule // ang_link_partner

// File: bench/ang_autoneg_bench.sv
// testbench for the negotiation block: straps, registers, pages, parallel detect, restart
`timescale 1ns/1ps
`include "ang_defs.vh"

module ang_autoneg_bench;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hi = 1'b0;
   logic lo = 1'b0;
   logic mdc = 1'b0;
   logic mdio_drv = 1'b1;
   wire mdio_o, mdio_oe, rpv, pd100, pd10, lok, flp_tx, tx_halt, speed_100, full_duplex, an_done;
   wire [15:0] rx_page, tx_word;
   wire mdio_i = mdio_oe ? mdio_o : mdio_drv; // pull-up when nobody drives
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   logic [15:0] rd, adv, w, pg;
   logic [2:0] r;

   ang_autoneg #(.PHY_ADDR(5'h01), .BREAK_CYCLES(32'h0000_0014)) ang_autoneg_i (.clk(clk),
      .sys_rst(sys_rst), .adv_strap_hi(hi), .adv_strap_lo(lo), .mdc(mdc), .mdio_i(mdio_i),
      .mdio_o(mdio_o), .mdio_oe(mdio_oe), .rx_page_valid(rpv), .rx_page(rx_page),
      .pd_link_100(pd100), .pd_link_10(pd10), .link_ok(lok), .flp_tx(flp_tx),
      .tx_word(tx_word), .tx_halt(tx_halt), .speed_100(speed_100),
      .full_duplex(full_duplex), .an_done(an_done));
   ang_link_partner ang_link_partner_i (.clk(clk), .rx_page_valid(rpv), .rx_page(rx_page),
      .pd_link_100(pd100), .pd_link_10(pd10), .link_ok(lok));

   initial begin
      forever #25 clk = ~clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   // one management frame, 8 clk per mdc period; read bits sampled before each rise
   task automatic mgmt(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
      logic [31:0] f;
      f = {2'b01, op, 5'h01, ra, 2'b10, wd};
      for (int i = 31; i >= 0; i--) begin
         mdio_drv = (op == `ANG_OP_READ && i < 18) ? 1'b1 : f[i];
         cyc(4);
         if (i < 16)
            rd[i] = mdio_i;
         mdc = 1'b1;
         cyc(4);
         mdc = 1'b0;
      end
      mdio_drv = 1'b1;
      cyc(4);
   endtask

   task automatic rreg(input logic [4:0] ra, input string name, input logic [15:0] exp);
      mgmt(`ANG_OP_READ, ra, 16'h0000);
      chk(name, rd, exp);
   endtask

   task automatic do_reset(input logic h, input logic l);
      sys_rst = 1'b1;
      hi = h;
      lo = l;
      cyc(8);
      sys_rst = 1'b0;
      cyc(2);
   endtask

   // advertised bits 8..5 chosen by the strap pair
   function automatic logic [3:0] strap_adv(input logic h, input logic l);
      case ({h, l})
         2'b00: return 4'h3;
         2'b01: return 4'hC;
         2'b10: return 4'h5;
         default: return 4'hF;
      endcase
   endfunction

   // {found, speed 100, full duplex} by fixed priority
   function automatic logic [2:0] resolve(input logic [3:0] c);
      if (c[3]) return 3'h7;
      if (c[2]) return 3'h6;
      if (c[1]) return 3'h5;
      if (c[0]) return 3'h4;
      return 3'h0;
   endfunction

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // hang guard, well above the ~22k cycles the tests need at most
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         num_errors++;
         results();
      end
   end

   initial begin
      w = 16'($urandom(32'h0000_40D7));
      for (int s = 0; s < 4; s++) begin
         do_reset(s[1], s[0]);
         adv = {7'h00, strap_adv(s[1], s[0]), 5'h01};
         chk("tx_word", tx_word, adv);
         rreg(5'h04, "advert", adv);
      end
      rreg(5'h00, "control", 16'h3100);
      rreg(5'h01, "status", 16'h7849);
      rreg(5'h02, "unmapped", 16'h0000);
      $display("test straps done");

      for (int k = 0; k < 10; k++) begin
         ang_link_partner_i.levels(1'b1, 1'b0, 1'b0);
         w = (k == 2) ? 16'h0000 : 16'($urandom);
         adv = (w & 16'hA5E0) | 16'h0001;
         mgmt(`ANG_OP_WRITE, 5'h04, w);
         rreg(5'h04, "advert wr", adv);
         chk("tx_word", tx_word, adv);
         w = 16'($urandom);
         pg = {1'b0, w[14:0]};
         if (k == 1)
            pg[8:5] = ~adv[8:5];
         if (k % 3 == 0)
            ang_link_partner_i.page({1'b1, pg[14:0]});
         ang_link_partner_i.page(pg);
         cyc(2);
         r = resolve(adv[8:5] & pg[8:5]);
         if (r[2]) begin
            chk("mode", {13'h0000, an_done, speed_100, full_duplex}, {13'h0000, r});
            rreg(5'h10, "line", {11'h000, 1'b1, 1'b0, r[0], !r[1], 1'b1});
            rreg(5'h05, "partner", pg);
            rreg(5'h01, "status", 16'h786D | {11'h000, pg[13], 4'h0});
            mgmt(`ANG_OP_READ, 5'h06, 16'h0000);
            chk("expansion", rd & 16'h001F, {11'h000, 1'b0, k % 3 == 0, 3'h7});
            mgmt(`ANG_OP_WRITE, 5'h00, {2'b00, !r[1], 1'b1, 2'h0, 1'b0, !r[0], 8'h00});
            chk("mode kept", {13'h0000, an_done, speed_100, full_duplex}, {13'h0000, r});
         end else
            chk("no done", {15'h0000, an_done}, 16'h0000);
         ang_link_partner_i.levels(1'b0, 1'b0, 1'b0);
         cyc(3);
         chk("bursts", {15'h0000, flp_tx}, 16'h0001);
      end
      $display("test pages done");

      // restart, then parallel detect: 100 only, 10 only, both
      for (int k = 0; k < 3; k++) begin
         ang_link_partner_i.levels(1'b0, 1'b0, 1'b0);
         mgmt(`ANG_OP_WRITE, 5'h00, 16'h1200);
         chk("halt", {14'h0000, tx_halt, flp_tx}, 16'h0002);
         for (int n = 0; n < 40 && !flp_tx; n++)
            cyc(1);
         chk("resume", {14'h0000, tx_halt, flp_tx}, 16'h0001);
         ang_link_partner_i.levels(1'b1, k != 1, k != 0);
         cyc(3);
         if (k < 2) begin
            chk("pd mode", {13'h0000, an_done, speed_100, full_duplex}, {14'h0001, k == 0, 1'b0});
            rreg(5'h05, "pd partner", (k == 0) ? 16'h0081 : 16'h0021);
         end else begin
            chk("pd both", {15'h0000, an_done}, 16'h0000);
            mgmt(`ANG_OP_READ, 5'h06, 16'h0000);
            chk("pd fault", rd & 16'h0015, 16'h0014);
            ang_link_partner_i.levels(1'b0, 1'b0, 1'b0);
            // the clearing read still reports the flag set since the last read
            mgmt(`ANG_OP_READ, 5'h06, 16'h0000);
            chk("fault held", rd & 16'h0010, 16'h0010);
            mgmt(`ANG_OP_READ, 5'h06, 16'h0000);
            chk("fault clear", rd & 16'h0010, 16'h0000);
         end
      end
      $display("test restart done");

      // negotiation off: speed and duplex bits force the mode
      for (int k = 0; k < 4; k++) begin
         mgmt(`ANG_OP_WRITE, 5'h00, {2'b00, k[1], 1'b0, 2'h0, 1'b0, k[0], 8'h00});
         chk("forced", {13'h0000, an_done, speed_100, full_duplex}, {14'h0000, k[1:0]});
      end
      mgmt(`ANG_OP_WRITE, 5'h00, 16'h8000);
      rreg(5'h04, "soft reset advert", 16'h01E1);
      rreg(5'h00, "soft reset control", 16'h3100);
      $display("test forced done");
      results();
   end
endmodule // ang_autoneg_bench
